// >>> scr_pkg.sv
// shared constants and carrier types of the sensor conditioner register bank
package scr_pkg;
    // byte addresses of the map
    localparam logic [7:0] SCR_ADDR_CFG = 8'h80;
    localparam logic [7:0] SCR_ADDR_ROW1 = 8'h81;
    localparam logic [7:0] SCR_ADDR_ROW2 = 8'h82;
    localparam logic [7:0] SCR_ADDR_CODE1 = 8'h83;
    localparam logic [7:0] SCR_ADDR_CODE2 = 8'h84;
    localparam logic [7:0] SCR_ADDR_SRC = 8'h85;
    localparam logic [7:0] SCR_ADDR_PERMIT = 8'h86;
    localparam logic [7:0] SCR_ADDR_RESULT = 8'h87;
    localparam logic [3:0] SCR_MAP_PAGE = 4'h8;
    localparam logic [7:0] SCR_RSVD_FIRST = 8'h88;
    // general_config fields
    localparam int SCR_VREF_BIT = 2;
    localparam int SCR_FILTER_BIT = 4;
    localparam int SCR_PERSIST_BIT = 5;
    localparam int SCR_GEN1_BIT = 6;
    localparam int SCR_GEN2_BIT = 7;
    // manual_source_select fields
    localparam int SCR_T1_SEL_BIT = 4;
    localparam int SCR_C1_SEL_BIT = 5;
    localparam int SCR_T2_SEL_BIT = 6;
    localparam int SCR_C2_SEL_BIT = 7;
    // write_permit
    localparam int SCR_PERMIT_BIT = 7;
    localparam logic [7:0] SCR_PERMIT_SET = 8'h80;
    localparam logic [7:0] SCR_PERMIT_CLR = 8'h00;
    // row registers keep only six bits
    localparam logic [7:0] SCR_ROW_MASK = 8'h3f;
    // values after reset
    localparam logic [7:0] SCR_CFG_RST = 8'h08;
    localparam logic [7:0] SCR_BYTE_RST = 8'h00;
    // filter
    localparam int SCR_FILT_MATCH = 4;
    localparam int SCR_FILT_CMP_BITS = 6;
    localparam logic [2:0] SCR_FILT_CNT_RST = 3'h0;

    typedef enum logic [1:0] {
        SCR_LOAD = 2'b01,
        SCR_RUN = 2'b10
    } scr_phase_t;

    // one register access from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } scr_req_t;

    // byte handed to the nonvolatile write engine
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } scr_nv_wr_t;

    // stored contents of the nonvolatile cells, seen at power-up
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] row1;
        logic [7:0] row2;
        logic [7:0] code1;
        logic [7:0] code2;
        logic [7:0] src;
    } scr_nv_image_t;
endpackage : scr_pkg

// >>> scr_adc_filter.sv
// conversion result holder with agreement filter
`timescale 1ns/10ps
module scr_adc_filter #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic bypass,
    // conversions
    input wire logic convValid,
    input wire logic [W-1:0] convData,
    // held result
    output logic [W-1:0] result
);
    import scr_pkg::*;

    typedef struct packed {
        logic [W-1:0] prev;
        logic [2:0] count;
        logic [W-1:0] result;
    } scr_filt_state_t;

    scr_filt_state_t state_q, state_d;
    logic same;

    assign same = convData[W-1 -: SCR_FILT_CMP_BITS] == state_q.prev[W-1 -: SCR_FILT_CMP_BITS];

    always_comb begin
        state_d = state_q;
        if (convValid) begin
            state_d.prev = convData;
            if (bypass) begin
                state_d.result = convData;
                state_d.count = SCR_FILT_CNT_RST;
            end else begin
                // first conversion of a run counts as one
                state_d.count = (same && state_q.count != SCR_FILT_CNT_RST) ?
                    state_q.count + 3'h1 : 3'h1;
                if (state_d.count == 3'(SCR_FILT_MATCH)) begin
                    state_d.result = convData;
                    state_d.count = SCR_FILT_CNT_RST;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign result = state_q.result;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_bypass_update;
        bypass && convValid |=> result == $past(convData);
    endproperty
    a_bypass_update: assert property (p_bypass_update) else $error("bypass result stale");

    property p_filter_hold;
        !bypass && convValid && state_q.count != 3'(SCR_FILT_MATCH - 1)
            |=> $stable(result);
    endproperty
    a_filter_hold: assert property (p_filter_hold) else $error("filter updated early");

    property p_filter_fire;
        !bypass && convValid && same && state_q.count == 3'(SCR_FILT_MATCH - 1)
            |=> result == $past(convData);
    endproperty
    a_filter_fire: assert property (p_filter_fire) else $error("filter missed update");
endmodule : scr_adc_filter

// >>> scr_ctrl_regs.sv
// control and status register bank of the dual-channel sensor conditioner
// Behaviour
// - filter bypass set: result refreshed every conversion
// - bypass clear: refresh after four matching six-bit results
// - persist clear: bytes 81h-84h kept volatile only
// - persist set: bytes 81h-84h also go nonvolatile
// - generator 1 sources at 0, sinks at 1
// - addresses 88h-8Fh reserved, no function
// - bit 7 of 86h is write permit latch
// - generator 2 sources at 0, sinks at 1
// - table addressed by converter or manual row field
// - converter fed by table row or manual code
// - writes refused without permit; 80h sets, 00h clears
`timescale 1ns/10ps
module scr_ctrl_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access from the serial front end
    input wire scr_pkg::scr_req_t req,
    output logic rdValid,
    output logic [7:0] rdData,
    output logic wrAck,
    output logic wrNack,
    // nonvolatile cells
    input wire scr_pkg::scr_nv_image_t nvImage,
    output scr_pkg::scr_nv_wr_t nvWr,
    // converter and tables
    input wire logic convValid,
    input wire logic [7:0] convData,
    input wire logic [7:0] table1Data,
    input wire logic [7:0] table2Data,
    output logic [5:0] table1Addr,
    output logic [5:0] table2Addr,
    output logic [7:0] converter1Code,
    output logic [7:0] converter2Code,
    // analog configuration
    output logic gen1Sink,
    output logic gen2Sink,
    output logic vrefExternal
);
    import scr_pkg::*;

    typedef struct packed {
        scr_phase_t phase;
        logic [7:0] cfg;
        logic [7:0] row1;
        logic [7:0] row2;
        logic [7:0] code1;
        logic [7:0] code2;
        logic [7:0] src;
        logic permit;
        logic rdValid;
        logic [7:0] rdData;
        logic wrAck;
        logic wrNack;
        scr_nv_wr_t nvWr;
        logic [5:0] t1Addr;
        logic [5:0] t2Addr;
        logic [7:0] c1Code;
        logic [7:0] c2Code;
    } scr_top_state_t;

    scr_top_state_t state_q, state_d;
    logic [7:0] resultByte;
    logic inMap;
    logic allowed;
    logic persist;

    ////////////////////////////////////////////////////////////////////////////
    // conversion result

    scr_adc_filter #(
        .W(8)
    ) u_filter (
        .clk(clk),
        .rst_n(rst_n),
        .bypass(state_q.cfg[SCR_FILTER_BIT]),
        .convValid(convValid),
        .convData(convData),
        .result(resultByte)
    );

    ////////////////////////////////////////////////////////////////////////////
    // access decode

    assign inMap = req.addr[7:4] == SCR_MAP_PAGE;
    // the latch itself must stay writable or it could never be set
    assign allowed = state_q.permit || req.addr == SCR_ADDR_PERMIT;
    assign persist = state_q.cfg[SCR_PERSIST_BIT];

    always_comb begin
        state_d = state_q;
        state_d.rdValid = 1'b0;
        state_d.wrAck = 1'b0;
        state_d.wrNack = 1'b0;
        state_d.nvWr.valid = 1'b0;
        unique case (state_q.phase)
            SCR_LOAD: begin
                // power-up copy of the nonvolatile cells, permit stays clear
                state_d.cfg = nvImage.cfg;
                state_d.row1 = nvImage.row1 & SCR_ROW_MASK;
                state_d.row2 = nvImage.row2 & SCR_ROW_MASK;
                state_d.code1 = nvImage.code1;
                state_d.code2 = nvImage.code2;
                state_d.src = nvImage.src;
                state_d.phase = SCR_RUN;
            end
            SCR_RUN: begin
                if (req.rd) begin
                    state_d.rdValid = 1'b1;
                    unique case (req.addr)
                        SCR_ADDR_CFG: state_d.rdData = state_q.cfg;
                        SCR_ADDR_ROW1: state_d.rdData = state_q.row1;
                        SCR_ADDR_ROW2: state_d.rdData = state_q.row2;
                        SCR_ADDR_CODE1: state_d.rdData = state_q.code1;
                        SCR_ADDR_CODE2: state_d.rdData = state_q.code2;
                        SCR_ADDR_SRC: state_d.rdData = state_q.src;
                        SCR_ADDR_PERMIT: state_d.rdData = {state_q.permit, 7'h00};
                        SCR_ADDR_RESULT: state_d.rdData = resultByte;
                        default: state_d.rdData = SCR_BYTE_RST;
                    endcase
                end else if (req.wr) begin
                    if (inMap && allowed) begin
                        state_d.wrAck = 1'b1;
                        state_d.nvWr.addr = req.addr;
                        state_d.nvWr.data = req.data;
                        unique case (req.addr)
                            SCR_ADDR_CFG: begin
                                state_d.cfg = req.data;
                                state_d.nvWr.valid = 1'b1;
                            end
                            SCR_ADDR_ROW1: begin
                                state_d.row1 = req.data & SCR_ROW_MASK;
                                state_d.nvWr.data = req.data & SCR_ROW_MASK;
                                state_d.nvWr.valid = persist;
                            end
                            SCR_ADDR_ROW2: begin
                                state_d.row2 = req.data & SCR_ROW_MASK;
                                state_d.nvWr.data = req.data & SCR_ROW_MASK;
                                state_d.nvWr.valid = persist;
                            end
                            SCR_ADDR_CODE1: begin
                                state_d.code1 = req.data;
                                state_d.nvWr.valid = persist;
                            end
                            SCR_ADDR_CODE2: begin
                                state_d.code2 = req.data;
                                state_d.nvWr.valid = persist;
                            end
                            SCR_ADDR_SRC: begin
                                state_d.src = req.data;
                                state_d.nvWr.valid = 1'b1;
                            end
                            SCR_ADDR_PERMIT: begin
                                // other patterns leave the latch alone
                                if (req.data == SCR_PERMIT_SET) begin
                                    state_d.permit = 1'b1;
                                end else if (req.data == SCR_PERMIT_CLR) begin
                                    state_d.permit = 1'b0;
                                end
                            end
                            default: begin
                                // result and reserved bytes ignore writes
                                state_d.nvWr.valid = 1'b0;
                            end
                        endcase
                    end else begin
                        state_d.wrNack = 1'b1;
                    end
                end
            end
            default: state_d.phase = SCR_LOAD;
        endcase

        // table addressing and converter inputs
        state_d.t1Addr = state_q.src[SCR_T1_SEL_BIT] ?
            state_q.row1[5:0] : resultByte[7:2];
        state_d.t2Addr = state_q.src[SCR_T2_SEL_BIT] ?
            state_q.row2[5:0] : resultByte[7:2];
        state_d.c1Code = state_q.src[SCR_C1_SEL_BIT] ? state_q.code1 : table1Data;
        state_d.c2Code = state_q.src[SCR_C2_SEL_BIT] ? state_q.code2 : table2Data;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '0;
            state_q.phase <= SCR_LOAD;
            state_q.cfg <= SCR_CFG_RST;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rdValid = state_q.rdValid;
    assign rdData = state_q.rdData;
    assign wrAck = state_q.wrAck;
    assign wrNack = state_q.wrNack;
    assign nvWr = state_q.nvWr;
    assign table1Addr = state_q.t1Addr;
    assign table2Addr = state_q.t2Addr;
    assign converter1Code = state_q.c1Code;
    assign converter2Code = state_q.c2Code;
    assign gen1Sink = state_q.cfg[SCR_GEN1_BIT];
    assign gen2Sink = state_q.cfg[SCR_GEN2_BIT];
    assign vrefExternal = state_q.cfg[SCR_VREF_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic running;
    assign running = state_q.phase == SCR_RUN;

    property p_locked_nack;
        running && req.wr && !req.rd && !state_q.permit && req.addr != SCR_ADDR_PERMIT
            |=> wrNack && !wrAck && !nvWr.valid && $stable(state_q.cfg) && $stable(state_q.src);
    endproperty
    a_locked_nack: assert property (p_locked_nack) else $error("locked write accepted");

    property p_permit_set;
        running && req.wr && !req.rd && req.addr == SCR_ADDR_PERMIT && req.data == SCR_PERMIT_SET
            |=> state_q.permit && wrAck;
    endproperty
    a_permit_set: assert property (p_permit_set) else $error("permit not set");

    property p_permit_clear;
        running && req.wr && !req.rd && req.addr == SCR_ADDR_PERMIT && req.data == SCR_PERMIT_CLR
            |=> !state_q.permit;
    endproperty
    a_permit_clear: assert property (p_permit_clear) else $error("permit not cleared");

    property p_permit_read;
        running && req.rd && req.addr == SCR_ADDR_PERMIT
            |=> rdValid && rdData == {$past(state_q.permit), 7'h00};
    endproperty
    a_permit_read: assert property (p_permit_read) else $error("permit read wrong");

    property p_volatile_row;
        running && req.wr && !req.rd && state_q.permit && !persist
            && req.addr >= SCR_ADDR_ROW1 && req.addr <= SCR_ADDR_CODE2
            |=> wrAck && !nvWr.valid;
    endproperty
    a_volatile_row: assert property (p_volatile_row) else $error("volatile byte stored");

    property p_persist_row;
        running && req.wr && !req.rd && state_q.permit && persist
            && req.addr >= SCR_ADDR_ROW1 && req.addr <= SCR_ADDR_CODE2
            |=> nvWr.valid && nvWr.addr == $past(req.addr);
    endproperty
    a_persist_row: assert property (p_persist_row) else $error("persistent byte dropped");

    property p_row_mask;
        state_q.row1[7:6] == 2'h0 && state_q.row2[7:6] == 2'h0;
    endproperty
    a_row_mask: assert property (p_row_mask) else $error("row reserved bits set");

    property p_result_read;
        running && req.rd && req.addr == SCR_ADDR_RESULT |=> rdData == $past(resultByte);
    endproperty
    a_result_read: assert property (p_result_read) else $error("result read wrong");

    property p_reserved_read;
        running && req.rd && req.addr >= SCR_RSVD_FIRST |=> rdData == SCR_BYTE_RST;
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("reserved read nonzero");

    property p_table_src;
        running && !state_q.src[SCR_T1_SEL_BIT] && $stable(resultByte)
            |=> table1Addr == $past(resultByte[7:2]);
    endproperty
    a_table_src: assert property (p_table_src) else $error("table1 address wrong");

    property p_dac_src;
        running && state_q.src[SCR_C2_SEL_BIT] |=> converter2Code == $past(state_q.code2);
    endproperty
    a_dac_src: assert property (p_dac_src) else $error("converter2 code wrong");

    property p_polarity;
        running && req.wr && !req.rd && state_q.permit && req.addr == SCR_ADDR_CFG
            |=> gen1Sink == $past(req.data[SCR_GEN1_BIT])
            && gen2Sink == $past(req.data[SCR_GEN2_BIT]);
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity mismatch");
endmodule : scr_ctrl_regs

// >>> scr_nv_tables.sv
// nonvolatile cells and look-up tables standing beside the register bank
`timescale 1ns/10ps
module scr_nv_tables (
    // clock
    input wire logic clk,
    // nonvolatile cells
    input wire scr_pkg::scr_nv_wr_t nvWr,
    output scr_pkg::scr_nv_image_t nvImage,
    // tables
    input wire logic [5:0] table1Addr,
    input wire logic [5:0] table2Addr,
    output logic [7:0] table1Data,
    output logic [7:0] table2Data
);
    import scr_pkg::*;

    // factory state; cells keep their contents across the bank's reset
    scr_nv_image_t cells = '{cfg: SCR_CFG_RST, default: 8'h00};

    assign nvImage = cells;
    // rows differ per address so a wrong row shows at the converter code
    assign table1Data = {~table1Addr[1:0], table1Addr};
    assign table2Data = {table2Addr, 2'b01};

    ////////////////////////////////////////////////////////////////////////
    // only bytes handed over are stored; volatile writes never get here
    always @(posedge clk) begin
        if (nvWr.valid === 1'b1) begin
            case (nvWr.addr)
                SCR_ADDR_CFG: cells.cfg <= nvWr.data;
                SCR_ADDR_ROW1: cells.row1 <= nvWr.data;
                SCR_ADDR_ROW2: cells.row2 <= nvWr.data;
                SCR_ADDR_CODE1: cells.code1 <= nvWr.data;
                SCR_ADDR_CODE2: cells.code2 <= nvWr.data;
                SCR_ADDR_SRC: cells.src <= nvWr.data;
                default: ;
            endcase
        end
    end
endmodule : scr_nv_tables

// >>> testbench.sv
// self-checking bench of the sensor conditioner register bank
`timescale 1ns/10ps
module testbench;
    import scr_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    scr_req_t req = '0;
    logic convValid = 1'b0;
    logic [7:0] convData = 8'h00;
    logic rdValid, wrAck, wrNack, gen1Sink, gen2Sink, vrefExternal;
    logic [7:0] rdData, table1Data, table2Data, converter1Code, converter2Code;
    logic [5:0] table1Addr, table2Addr;
    scr_nv_image_t nvImage;
    scr_nv_wr_t nvWr;
    int errors = 0;
    int num_checks = 0;
    int seed = 14858;
    logic [10:0] expQ[$];
    logic [7:0] v, a, c1, c2, cfg;

    always #2.5 clk = ~clk;

    scr_ctrl_regs scr_ctrl_regs_inst (.clk(clk), .rst_n(rst_n), .req(req),
        .rdValid(rdValid), .rdData(rdData), .wrAck(wrAck), .wrNack(wrNack),
        .nvImage(nvImage), .nvWr(nvWr), .convValid(convValid), .convData(convData),
        .table1Data(table1Data), .table2Data(table2Data), .table1Addr(table1Addr),
        .table2Addr(table2Addr), .converter1Code(converter1Code),
        .converter2Code(converter2Code), .gen1Sink(gen1Sink), .gen2Sink(gen2Sink),
        .vrefExternal(vrefExternal));

    scr_nv_tables scr_nv_tables_inst (.clk(clk), .nvWr(nvWr), .nvImage(nvImage),
        .table1Addr(table1Addr), .table2Addr(table2Addr),
        .table1Data(table1Data), .table2Data(table2Data));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        // a request that never got its answer must not slip through
        check("unanswered", 11'(expQ.size()), 11'h000);
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    // one request, then a free edge so the strobe is never re-driven at once
    task automatic access(input logic w, input logic [7:0] ad, input logic [7:0] d,
        input logic [10:0] exp);
        @(posedge clk);
        req <= '{wr: w, rd: ~w, addr: ad, data: d};
        expQ.push_back(exp);
        @(posedge clk);
        req <= '0;
    endtask : access

    task automatic rd(input logic [7:0] ad, input logic [7:0] d);
        access(1'b0, ad, 8'h00, {3'b100, d});
    endtask : rd

    task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic ok);
        access(1'b1, ad, d, {1'b0, ok, ~ok, 8'h00});
    endtask : wr

    task automatic conv(input logic [7:0] d);
        @(posedge clk);
        convValid <= 1'b1;
        convData <= d;
        @(posedge clk);
        convValid <= 1'b0;
    endtask : conv

    task automatic settle;
        repeat (3) @(posedge clk);
        // look between edges, away from the launching edge
        @(negedge clk);
    endtask : settle

    task automatic power_cycle;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : power_cycle

    ////////////////////////////////////////////////////////////////////////
    // answers come in request order, so the oldest note is the one due
    always @(negedge clk) begin
        if (rdValid === 1'b1 || wrAck === 1'b1 || wrNack === 1'b1) begin
            if (expQ.size() == 0) begin
                check("stray answer", {rdValid, wrAck, wrNack, rdData}, 11'h000);
            end else begin
                check("answer", {rdValid, wrAck, wrNack, rdValid ? rdData : 8'h00},
                    expQ.pop_front());
            end
        end
    end

    initial begin
        #100000;
        errors++;
        $display("watchdog expired");
        test_done();
    end

    initial begin
        power_cycle();
        rd(SCR_ADDR_CFG, SCR_CFG_RST);
        for (int i = 1; i < 8; i++) begin
            rd(SCR_ADDR_CFG + 8'(i), SCR_BYTE_RST);
        end
        rd(8'h8a, 8'h00);
        rd(8'h40, 8'h00);
        $display("test reset values done");

        wr(SCR_ADDR_ROW1, 8'h15, 1'b0);
        rd(SCR_ADDR_ROW1, 8'h00);
        wr(SCR_ADDR_PERMIT, 8'h55, 1'b1);
        rd(SCR_ADDR_PERMIT, 8'h00);
        wr(SCR_ADDR_PERMIT, SCR_PERMIT_SET, 1'b1);
        rd(SCR_ADDR_PERMIT, 8'h80);
        wr(SCR_ADDR_ROW1, 8'hff, 1'b1);
        rd(SCR_ADDR_ROW1, 8'h3f);
        wr(SCR_ADDR_RESULT, 8'ha5, 1'b1);
        rd(SCR_ADDR_RESULT, 8'h00);
        wr(8'h8c, 8'h77, 1'b1);
        rd(8'h8c, 8'h00);
        wr(8'h40, 8'h12, 1'b0);
        wr(SCR_ADDR_PERMIT, SCR_PERMIT_CLR, 1'b1);
        wr(SCR_ADDR_CODE1, 8'h33, 1'b0);
        rd(SCR_ADDR_CODE1, 8'h00);
        wr(SCR_ADDR_PERMIT, SCR_PERMIT_SET, 1'b1);
        $display("test write permit done");

        for (int i = 0; i < 4; i++) begin
            cfg = {i[1], i[0], 1'b0, 1'b1, 1'b1, ~i[0], 2'b00};
            wr(SCR_ADDR_CFG, cfg, 1'b1);
            rd(SCR_ADDR_CFG, cfg);
            settle();
            check("gen1Sink", 11'(gen1Sink), 11'(i[0]));
            check("gen2Sink", 11'(gen2Sink), 11'(i[1]));
            check("vrefExternal", 11'(vrefExternal), {10'h000, ~i[0]});
        end
        $display("test analog modes done");

        v = 8'($random(seed));
        conv(v);
        settle();
        rd(SCR_ADDR_RESULT, v);
        cfg[SCR_FILTER_BIT] = 1'b0;
        wr(SCR_ADDR_CFG, cfg, 1'b1);
        a = {~v[7:2], 2'b00};
        for (int i = 0; i < 3; i++) begin
            conv(a | 8'(i));
        end
        settle();
        rd(SCR_ADDR_RESULT, v);
        conv(a | 8'h03);
        settle();
        rd(SCR_ADDR_RESULT, a | 8'h03);
        $display("test filter done");

        settle();
        check("table1Addr", 11'(table1Addr), 11'(a[7:2]));
        check("table2Addr", 11'(table2Addr), 11'(a[7:2]));
        check("converter1Code", 11'(converter1Code), {3'b000, ~a[3:2], a[7:2]});
        check("converter2Code", 11'(converter2Code), {3'b000, a[7:2], 2'b01});
        c1 = 8'($random(seed));
        c2 = 8'($random(seed));
        wr(SCR_ADDR_CODE1, c1, 1'b1);
        wr(SCR_ADDR_ROW2, 8'h2a, 1'b1);
        wr(SCR_ADDR_SRC, 8'hf0, 1'b1);
        cfg[SCR_PERSIST_BIT] = 1'b1;
        wr(SCR_ADDR_CFG, cfg, 1'b1);
        wr(SCR_ADDR_CODE2, c2, 1'b1);
        settle();
        check("table1Addr", 11'(table1Addr), 11'h03f);
        check("table2Addr", 11'(table2Addr), 11'h02a);
        check("converter1Code", 11'(converter1Code), 11'(c1));
        check("converter2Code", 11'(converter2Code), 11'(c2));
        wr(SCR_ADDR_ROW1, 8'hff, 1'b1);
        $display("test manual select done");

        power_cycle();
        rd(SCR_ADDR_CODE1, 8'h00);
        rd(SCR_ADDR_ROW1, 8'h3f);
        rd(SCR_ADDR_ROW2, 8'h00);
        rd(SCR_ADDR_CODE2, c2);
        rd(SCR_ADDR_CFG, cfg);
        rd(SCR_ADDR_SRC, 8'hf0);
        rd(SCR_ADDR_PERMIT, 8'h00);
        settle();
        $display("test power cycle done");
        test_done();
    end
endmodule : testbench
